// File: shared/smp_defines.vh
`ifndef SMP_DEFINES_VH
`define SMP_DEFINES_VH

// ------------------------------------------------------------
// Characters
// ------------------------------------------------------------
`define SMP_CH_NL      8'h0a
`define SMP_CH_SPACE   8'h20
`define SMP_CH_COLON   8'h3a
`define SMP_CH_SEMI    8'h3b
`define SMP_CH_QUERY   8'h3f
`define SMP_CH_STAR    8'h2a

// ------------------------------------------------------------
// Keyword codes (0 = none, 1f = other / unknown)
// ------------------------------------------------------------
`define SMP_KW_NONE    5'h00
`define SMP_KW_ABOR    5'h01
`define SMP_KW_CAL     5'h02
`define SMP_KW_DISP    5'h03
`define SMP_KW_INIT    5'h04
`define SMP_KW_LIST    5'h05
`define SMP_KW_MEAS    5'h06
`define SMP_KW_OUTP    5'h07
`define SMP_KW_SOUR    5'h08
`define SMP_KW_STAT    5'h09
`define SMP_KW_SYST    5'h0a
`define SMP_KW_TRIG    5'h0b
`define SMP_KW_VOLT    5'h0c
`define SMP_KW_CURR    5'h0d
`define SMP_KW_FUNC    5'h0e
`define SMP_KW_OPER    5'h0f
`define SMP_KW_PRES    5'h10
`define SMP_KW_QUES    5'h11
`define SMP_KW_OTHER   5'h1f

// ------------------------------------------------------------
// Error codes
// ------------------------------------------------------------
`define SMP_ERR_NONE   3'h0
`define SMP_ERR_SPELL  3'h1
`define SMP_ERR_UNDEF  3'h2
`define SMP_ERR_SYNTAX 3'h3
`define SMP_ERR_LONG   3'h4

`endif

// File: rtl/smp_parser.v
`timescale 1ns/1ps
`include "smp_defines.vh"

module smp_parser #(
  parameter KW_MAX   = 12,
  parameter DATA_MAX = 16,
  parameter DEPTH_W  = 3
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  srst,
  input  wire                  ce,
  // Character stream
  input  wire                  char_valid,
  input  wire [7:0]            char_data,
  // Keyword events
  output reg                   kw_valid,
  output reg  [4:0]            kw_code,
  output reg  [4:0]            kw_parent,
  output reg  [DEPTH_W-1:0]    kw_level,
  output reg                   kw_known,
  // Message unit events
  output reg                   unit_valid,
  output reg                   unit_query,
  output reg                   unit_has_data,
  output reg                   unit_numeric,
  output reg  [DATA_MAX*8-1:0] unit_data,
  output reg  [4:0]            unit_len,
  output reg                   msg_done,
  // Errors
  output reg                   err_valid,
  output reg  [2:0]            err_code
);

  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  localparam ST_START = 3'd0;
  localparam ST_KW    = 3'd1;
  localparam ST_QRY   = 3'd2;
  localparam ST_DATA  = 3'd3;
  localparam ST_DISC  = 3'd4;
  localparam ST_SEP   = 3'd5;

  reg [2:0]            state;
  reg [KW_MAX*8-1:0]   kw_buf;
  reg [3:0]            kw_cnt;
  reg                  kw_over;
  reg [4:0]            cur_parent;
  reg [4:0]            last_parent;
  reg [DEPTH_W-1:0]    cur_level;
  reg [DEPTH_W-1:0]    last_level;
  reg                  q_flag;
  reg                  lead_colon;
  reg [4:0]            data_cnt;
  reg                  data_num;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function [7:0] to_upper;
    input [7:0] c;
    begin
      if (c >= 8'h61 && c <= 8'h7a)
        to_upper = c - 8'h20;
      else
        to_upper = c;
    end
  endfunction

  function is_vowel;
    input [7:0] c;
    begin
      is_vowel = (c == 8'h41) || (c == 8'h45) || (c == 8'h49) ||
                 (c == 8'h4f) || (c == 8'h55);
    end
  endfunction

  // Accepts short or long form of a long word held left-aligned in 12 bytes.
  // Anything in between is refused, which is why a partial word like
  // OPERA under STATUS is an error rather than a loose prefix match.
  function form_ok;
    input [KW_MAX*8-1:0] got;
    input [3:0]          got_n;
    input [95:0]         word;
    input [3:0]          word_n;
    reg   [3:0]          sh;
    reg   [3:0]          i;
    reg                  same;
    begin
      if (word_n <= 4'd4)
        sh = word_n;
      else if (is_vowel(word[71:64]))
        sh = 4'd3;
      else
        sh = 4'd4;
      same = 1'b1;
      for (i = 4'd0; i < 4'd12; i = i + 4'd1) begin
        if (i < got_n && got[(KW_MAX-1-i)*8 +: 8] != word[(11-i)*8 +: 8])
          same = 1'b0;
      end
      form_ok = same && (got_n == sh || got_n == word_n);
    end
  endfunction

  // Keyword lookup relative to parent node
  function [4:0] lookup;
    input [KW_MAX*8-1:0] g;
    input [3:0]          n;
    input [4:0]          par;
    begin
      lookup = `SMP_KW_OTHER;
      if (par == `SMP_KW_NONE) begin
        if (form_ok(g, n, {"ABORT", 56'h0}, 4'd5))      lookup = `SMP_KW_ABOR;
        if (form_ok(g, n, {"CALIBRATE", 24'h0}, 4'd9))  lookup = `SMP_KW_CAL;
        if (form_ok(g, n, {"DISPLAY", 40'h0}, 4'd7))    lookup = `SMP_KW_DISP;
        if (form_ok(g, n, {"INITIATE", 32'h0}, 4'd8))   lookup = `SMP_KW_INIT;
        if (form_ok(g, n, {"LIST", 64'h0}, 4'd4))       lookup = `SMP_KW_LIST;
        if (form_ok(g, n, {"MEASURE", 40'h0}, 4'd7))    lookup = `SMP_KW_MEAS;
        if (form_ok(g, n, {"OUTPUT", 48'h0}, 4'd6))     lookup = `SMP_KW_OUTP;
        if (form_ok(g, n, {"SOURCE", 48'h0}, 4'd6))     lookup = `SMP_KW_SOUR;
        if (form_ok(g, n, {"STATUS", 48'h0}, 4'd6))     lookup = `SMP_KW_STAT;
        if (form_ok(g, n, {"SYSTEM", 48'h0}, 4'd6))     lookup = `SMP_KW_SYST;
        if (form_ok(g, n, {"TRIGGER", 40'h0}, 4'd7))    lookup = `SMP_KW_TRIG;
      end
      if (par == `SMP_KW_NONE || par == `SMP_KW_SOUR) begin
        // Source is optional, so its children also sit at the root
        if (form_ok(g, n, {"VOLTAGE", 40'h0}, 4'd7))    lookup = `SMP_KW_VOLT;
        if (form_ok(g, n, {"CURRENT", 40'h0}, 4'd7))    lookup = `SMP_KW_CURR;
        if (form_ok(g, n, {"FUNCTION", 32'h0}, 4'd8))   lookup = `SMP_KW_FUNC;
      end
      if (par == `SMP_KW_STAT) begin
        lookup = `SMP_KW_NONE;
        if (form_ok(g, n, {"OPERATION", 24'h0}, 4'd9))  lookup = `SMP_KW_OPER;
        if (form_ok(g, n, {"PRESET", 48'h0}, 4'd6))     lookup = `SMP_KW_PRES;
        if (form_ok(g, n, {"QUESTIONABLE"}, 4'd12))     lookup = `SMP_KW_QUES;
      end
    end
  endfunction

  wire [7:0] uc      = to_upper(char_data);
  wire       is_let  = (uc >= 8'h41 && uc <= 8'h5a);
  wire       is_kwch = is_let || (char_data >= 8'h30 && char_data <= 8'h39) ||
                       (char_data == `SMP_CH_STAR);
  wire       is_num  = (char_data >= 8'h30 && char_data <= 8'h39) || char_data == 8'h2b ||
                       char_data == 8'h2d || char_data == 8'h2e || char_data == 8'h45 ||
                       char_data == 8'h65;
  wire [4:0] found   = lookup(kw_buf, kw_cnt, cur_parent);

  // ----------------------------------------------------------
  // Parser
  // ----------------------------------------------------------
  // Finishes the keyword in kw_buf; spelling errors are caught before it is called.
  task close_kw;
    begin
      kw_valid  <= 1'b1;
      kw_parent <= cur_parent;
      kw_level  <= cur_level;
      kw_code   <= found;
      kw_known  <= (found != `SMP_KW_OTHER);
      // Unknown children are still tracked as a new parent level
      last_parent <= cur_parent;
      last_level  <= cur_level;
      cur_parent  <= found;
      cur_level   <= cur_level + {{(DEPTH_W-1){1'b0}}, 1'b1};
    end
  endtask

  task go_error;
    input [2:0] code;
    begin
      err_valid <= 1'b1;
      err_code  <= code;
      if (char_data == `SMP_CH_NL) begin
        // A bad terminator still ends the message, else the next one is lost
        cur_parent <= `SMP_KW_NONE;
        cur_level  <= {DEPTH_W{1'b0}};
        lead_colon <= 1'b1;
        q_flag     <= 1'b0;
        msg_done   <= 1'b1;
        state      <= ST_START;
      end else begin
        state <= ST_DISC;
      end
    end
  endtask

  task end_unit;
    input has_nl;
    begin
      unit_valid <= 1'b1;
      unit_query <= q_flag;
      unit_len   <= data_cnt;
      unit_has_data <= (state == ST_DATA) && (data_cnt != 5'd0);
      unit_numeric  <= data_num;
      msg_done   <= has_nl;
      q_flag     <= 1'b0;
      kw_cnt     <= 4'd0;
      lead_colon <= 1'b1;
      if (has_nl) begin
        cur_parent <= `SMP_KW_NONE;
        cur_level  <= {DEPTH_W{1'b0}};
        state      <= ST_START;
      end else begin
        state <= ST_SEP;
      end
    end
  endtask

  always @(posedge clk) begin
    if (srst) begin
      state       <= ST_START;
      kw_buf      <= {KW_MAX*8{1'b0}};
      kw_cnt      <= 4'd0;
      kw_over     <= 1'b0;
      cur_parent  <= `SMP_KW_NONE;
      last_parent <= `SMP_KW_NONE;
      cur_level   <= {DEPTH_W{1'b0}};
      last_level  <= {DEPTH_W{1'b0}};
      q_flag      <= 1'b0;
      lead_colon  <= 1'b1;
      data_cnt    <= 5'd0;
      data_num    <= 1'b1;
      kw_valid    <= 1'b0;
      kw_code     <= `SMP_KW_NONE;
      kw_parent   <= `SMP_KW_NONE;
      kw_level    <= {DEPTH_W{1'b0}};
      kw_known    <= 1'b0;
      unit_valid  <= 1'b0;
      unit_query  <= 1'b0;
      unit_has_data <= 1'b0;
      unit_numeric  <= 1'b0;
      unit_data   <= {DATA_MAX*8{1'b0}};
      unit_len    <= 5'd0;
      msg_done    <= 1'b0;
      err_valid   <= 1'b0;
      err_code    <= `SMP_ERR_NONE;
    end else if (ce) begin
      kw_valid   <= 1'b0;
      unit_valid <= 1'b0;
      msg_done   <= 1'b0;
      err_valid  <= 1'b0;
      if (char_valid) begin
        case (state)
          ST_START, ST_SEP: begin
            data_cnt <= 5'd0;
            data_num <= 1'b1;
            kw_cnt   <= 4'd0;
            kw_over  <= 1'b0;
            if (char_data == `SMP_CH_SPACE && state == ST_SEP) begin
              state <= ST_SEP;
            end else if (char_data == `SMP_CH_NL) begin
              end_unit(1'b1);
            end else if (char_data == `SMP_CH_COLON && lead_colon) begin
              cur_parent <= `SMP_KW_NONE;
              cur_level  <= {DEPTH_W{1'b0}};
              lead_colon <= 1'b0;
              state      <= ST_KW;
            end else if (is_kwch) begin
              if (state == ST_SEP) begin
                cur_parent <= last_parent;
                cur_level  <= last_level;
              end
              kw_buf     <= {uc, {(KW_MAX-1)*8{1'b0}}};
              kw_cnt     <= 4'd1;
              lead_colon <= 1'b0;
              state      <= ST_KW;
            end else begin
              go_error(`SMP_ERR_SYNTAX);
            end
          end
          ST_KW: begin
            if (is_kwch) begin
              if (kw_cnt == KW_MAX[3:0])
                kw_over <= 1'b1;
              else begin
                kw_buf[(KW_MAX-1-kw_cnt)*8 +: 8] <= uc;
                kw_cnt <= kw_cnt + 4'd1;
              end
            end else if (kw_cnt == 4'd0 || kw_over) begin
              go_error(kw_over ? `SMP_ERR_LONG : `SMP_ERR_SYNTAX);
            end else if (found == `SMP_KW_NONE) begin
              go_error(`SMP_ERR_SPELL);
            end else begin
              close_kw;
              kw_cnt <= 4'd0;
              // Optional keywords need no special path: a skipped level
              // simply never appears, and lookup accepts the child directly
              case (char_data)
                `SMP_CH_COLON: state <= ST_KW;
                `SMP_CH_QUERY: begin
                  q_flag <= 1'b1;
                  state  <= ST_QRY;
                end
                `SMP_CH_SPACE: state <= ST_DATA;
                `SMP_CH_SEMI:  end_unit(1'b0);
                `SMP_CH_NL:    end_unit(1'b1);
                default:       go_error(`SMP_ERR_SYNTAX);
              endcase
            end
          end
          ST_QRY: begin
            case (char_data)
              `SMP_CH_SPACE: state <= ST_DATA;
              `SMP_CH_SEMI:  end_unit(1'b0);
              `SMP_CH_NL:    end_unit(1'b1);
              default:       go_error(`SMP_ERR_SYNTAX);
            endcase
          end
          ST_DATA: begin
            if (char_data == `SMP_CH_SEMI) begin
              end_unit(1'b0);
            end else if (char_data == `SMP_CH_NL) begin
              end_unit(1'b1);
            end else if (char_data == `SMP_CH_SPACE && data_cnt == 5'd0) begin
              state <= ST_DATA;
            end else if (data_cnt == DATA_MAX[4:0]) begin
              go_error(`SMP_ERR_LONG);
            end else begin
              // Data is kept as raw text; numeric or string is a hint only
              unit_data[(DATA_MAX-1-data_cnt)*8 +: 8] <= char_data;
              data_cnt <= data_cnt + 5'd1;
              if (!is_num)
                data_num <= 1'b0;
            end
          end
          ST_DISC: begin
            if (char_data == `SMP_CH_NL) begin
              cur_parent <= `SMP_KW_NONE;
              cur_level  <= {DEPTH_W{1'b0}};
              lead_colon <= 1'b1;
              q_flag     <= 1'b0;
              kw_cnt     <= 4'd0;
              msg_done   <= 1'b1;
              state      <= ST_START;
            end
          end
          default: state <= ST_START;
        endcase
      end
    end
  end

endmodule // smp_parser

// File: tb/smp_parser_properties.sv
`timescale 1ns/1ps
`include "smp_defines.vh"
// ----------------------------------------
// Parser port checker
// ----------------------------------------
module smp_parser_properties #(
  parameter KW_MAX   = 12,
  parameter DATA_MAX = 16,
  parameter DEPTH_W  = 3
) (
  // Clock and reset
  input wire               clk,
  input wire               srst,
  input wire               ce,
  // Character stream
  input wire               char_valid,
  input wire [7:0]         char_data,
  // Events
  input wire               kw_valid,
  input wire [4:0]         kw_code,
  input wire [4:0]         kw_parent,
  input wire [DEPTH_W-1:0] kw_level,
  input wire               kw_known,
  input wire               unit_valid,
  input wire               msg_done,
  input wire               err_valid,
  input wire [2:0]         err_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Mirrors the discard span; an error on the newline itself opens none
  logic drop;
  wire  nl_in   = ce && char_valid && char_data == `SMP_CH_NL;
  wire  semi_in = ce && char_valid && char_data == `SMP_CH_SEMI;
  always @(posedge clk) begin
    if (srst) drop <= 1'b0;
    else if (ce && msg_done) drop <= 1'b0;
    else if (ce && err_valid) drop <= 1'b1;
  end
  property p_nl_done; nl_in |=> msg_done; endproperty
  a_nl_done: assert property (p_nl_done) else $error("newline not ended");
  property p_done_cause; msg_done && $past(ce) |-> $past(nl_in); endproperty
  a_done_cause: assert property (p_done_cause) else $error("end without newline");
  property p_semi_unit; semi_in && !drop && !err_valid |=> unit_valid || err_valid; endproperty
  a_semi_unit: assert property (p_semi_unit) else $error("semicolon lost");
  property p_root_parent; kw_valid && kw_level == 0 |-> kw_parent == `SMP_KW_NONE; endproperty
  a_root_parent: assert property (p_root_parent) else $error("root with parent");
  property p_deep_parent; kw_valid && kw_level != 0 |-> kw_parent != `SMP_KW_NONE; endproperty
  a_deep_parent: assert property (p_deep_parent) else $error("deep without parent");
  property p_known; kw_valid |-> kw_known == (kw_code != `SMP_KW_OTHER); endproperty
  a_known: assert property (p_known) else $error("known flag wrong");
  property p_err_code;
    err_valid |-> err_code inside {`SMP_ERR_SPELL, `SMP_ERR_SYNTAX, `SMP_ERR_LONG};
  endproperty
  a_err_code: assert property (p_err_code) else $error("bad error code");
  property p_drop; drop |-> !kw_valid && !unit_valid; endproperty
  a_drop: assert property (p_drop) else $error("event while dropping");
  property p_kw_once; kw_valid && ce |=> !kw_valid; endproperty
  a_kw_once: assert property (p_kw_once) else $error("keyword pulse too long");
  property p_stat_kids;
    kw_valid && kw_parent == `SMP_KW_STAT && !err_valid
      |-> kw_code inside {`SMP_KW_OPER, `SMP_KW_PRES, `SMP_KW_QUES};
  endproperty
  a_stat_kids: assert property (p_stat_kids) else $error("bad status child");
  c_deep: cover property (kw_valid && kw_level != 0);
  c_err: cover property (err_valid);
  c_drop_end: cover property (drop && nl_in);
endmodule // smp_parser_properties

bind smp_parser smp_parser_properties #(
  .KW_MAX(KW_MAX), .DATA_MAX(DATA_MAX), .DEPTH_W(DEPTH_W)
) smp_parser_properties_i (
  .clk(clk), .srst(srst), .ce(ce), .char_valid(char_valid), .char_data(char_data),
  .kw_valid(kw_valid), .kw_code(kw_code), .kw_parent(kw_parent), .kw_level(kw_level),
  .kw_known(kw_known), .unit_valid(unit_valid), .msg_done(msg_done),
  .err_valid(err_valid), .err_code(err_code)
);

// File: tb/smp_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote controller model
// ----------------------------------------
module smp_host (
  // Clock
  input wire         clk,
  // Enable, dropped only while no character is offered
  output logic       ce,
  // Character stream
  output logic       char_valid,
  output logic [7:0] char_data
);
  initial begin
    ce         = 1'b1;
    char_valid = 1'b0;
    char_data  = 8'h55;
  end
  // Idle line toggles char_data each gap cycle, starting from the inverse of the last character
  task automatic put(input logic [7:0] c, input bit slow);
    int gap;
    gap = slow ? $urandom_range(3) : 0;
    repeat (gap) begin
      char_valid = 1'b0;
      char_data  = ~char_data;
      ce         = 1'($urandom_range(1));
      @(negedge clk);
    end
    ce         = 1'b1;
    char_valid = 1'b1;
    char_data  = c;
    @(negedge clk);
  endtask
  task automatic send(input string s, input bit slow);
    foreach (s[i]) put(s[i], slow);
    put(8'h0a, slow);
    char_valid = 1'b0;
    char_data  = ~char_data;
  endtask
endmodule // smp_host

// File: tb/test_smp_parser.sv
`timescale 1ns/1ps
module test_smp_parser;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, srst, ce_q;
  wire ce, char_valid, kw_valid, kw_known, unit_valid, unit_query, unit_has_data;
  wire unit_numeric, msg_done, err_valid;
  wire [7:0] char_data;
  wire [4:0] kw_code, kw_parent, unit_len;
  wire [2:0] kw_level, err_code;
  wire [127:0] unit_data;
  int mismatches, samples_checked, msgs, tn;
  logic [12:0] gk[$], ek[$];
  logic [15:0] gu[$], eu[$];
  logic [2:0] ge[$], ee[$];
  string roots[14] = '{"ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE",
    "OUTPUT", "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE", "CURRENT", "FUNCTION"};
  smp_parser smp_parser_i (.clk(clk), .srst(srst), .ce(ce), .char_valid(char_valid),
    .char_data(char_data), .kw_valid(kw_valid), .kw_code(kw_code), .kw_parent(kw_parent),
    .kw_level(kw_level), .kw_known(kw_known), .unit_valid(unit_valid),
    .unit_query(unit_query), .unit_has_data(unit_has_data), .unit_numeric(unit_numeric),
    .unit_data(unit_data), .unit_len(unit_len), .msg_done(msg_done),
    .err_valid(err_valid), .err_code(err_code));
  smp_host smp_host_i (.clk(clk), .ce(ce), .char_valid(char_valid), .char_data(char_data));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Data byte and numeric flag mean nothing without data, so they are masked.
  // A pulse held over a low enable is seen again, so only fresh ones count.
  always @(posedge clk) ce_q <= ce;
  always @(negedge clk) if (!srst && ce_q) begin
    if (kw_valid) gk.push_back({kw_code, kw_parent, kw_level});
    if (unit_valid) gu.push_back({unit_query, unit_has_data, unit_has_data & unit_numeric,
      unit_len, unit_has_data ? unit_data[127:120] : 8'h00});
    if (err_valid) ge.push_back(err_code);
    if (msg_done) msgs++;
  end
  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic string short_form(input string w);
    if (w.len() <= 4) return w;
    return (w[3] inside {"A", "E", "I", "O", "U"}) ? w.substr(0, 2) : w.substr(0, 3);
  endfunction
  function automatic string mixcase(input string w);
    foreach (w[i]) if ($urandom_range(1)) w[i] = w[i] | 8'h20;
    return w;
  endfunction
  task automatic xk(input logic [4:0] c, p, input logic [2:0] l); ek.push_back({c, p, l});
  endtask
  task automatic xu(input logic q, h, n, input logic [4:0] len, input logic [7:0] b);
    eu.push_back({q, h, n, len, b});
  endtask
  task automatic miss(input string k, input logic [15:0] g, e);
    mismatches++;
    $display("[ERR] %0t %s got %h exp %h", $time, k, g, e);
  endtask
  task automatic check_kw(input logic [12:0] g, e);
    samples_checked++;
    if (g !== e) miss("keyword", 16'(g), 16'(e));
  endtask
  task automatic check_unit(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) miss("unit", g, e);
  endtask
  task automatic check_err(input logic [2:0] g, e);
    samples_checked++;
    if (g !== e) miss("error", 16'(g), 16'(e));
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Missing entries read as all ones, a value no real event carries
  task automatic run(input string s, input bit slow, input bit only_err = 0);
    int n, t;
    n = msgs;
    t = 0;
    smp_host_i.send(s, slow);
    while (msgs == n && t < 100) begin
      @(negedge clk);
      t++;
    end
    if (msgs == n) begin
      miss("end", 16'h0000, 16'h0001);
      tally_and_finish();
    end
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      if (!only_err && (i < gk.size() || i < ek.size()))
        check_kw(i < gk.size() ? gk[i] : '1, i < ek.size() ? ek[i] : '1);
      if (!only_err && (i < gu.size() || i < eu.size()))
        check_unit(i < gu.size() ? gu[i] : '1, i < eu.size() ? eu[i] : '1);
      if (i < ge.size() || i < ee.size())
        check_err(i < ge.size() ? ge[i] : '1, i < ee.size() ? ee[i] : '1);
    end
    $display("test %0d ended: %s", tn++, s);
    gk = {}; ek = {}; gu = {}; eu = {}; ge = {}; ee = {};
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    msgs = 0;
    tn = 0;
    void'($urandom(98203));
    repeat (5) @(negedge clk);
    srst = 1'b0;
    xk(5'h08, 5'h00, 3'h0); xk(5'h0c, 5'h08, 3'h1); xk(5'h0d, 5'h08, 3'h1);
    xu(1, 0, 0, 0, 0); xu(1, 0, 0, 0, 0);
    run("SOUR:VOLT?;CURR?", 0);
    xk(5'h04, 0, 0); xk(5'h0b, 0, 0); xk(5'h08, 0, 0); xk(5'h0d, 5'h08, 1); xk(5'h0c, 5'h08, 1);
    xu(0, 0, 0, 0, 0); xu(0, 0, 0, 0, 0); xu(1, 0, 0, 0, 0); xu(1, 0, 0, 0, 0);
    run(":INIT;:TRIG;:SOUR:CURR?;VOLT?", 0);
    xk(5'h09, 0, 0); xk(5'h0f, 5'h09, 1); xk(5'h10, 5'h09, 1); xk(5'h09, 0, 0);
    xk(5'h11, 5'h09, 1);
    xu(1, 0, 0, 0, 0); xu(0, 0, 0, 0, 0); xu(0, 0, 0, 0, 0);
    run("stat:oper?;PRES;:Status:Questionable", 0);
    xk(5'h0c, 0, 0); xk(5'h08, 0, 0); xk(5'h0c, 5'h08, 1);
    xu(0, 1, 1, 2, "1"); xu(1, 1, 0, 3, "M");
    run("VOLT 15;  sour:volt? MAX", 0);
    xk(5'h07, 0, 0); xu(0, 1, 0, 2, "O");
    run("OUTPut ON", 0);
    ee.push_back(3'h1);
    run("STAT:OPERA", 0, 1);
    ee.push_back(3'h1);
    run("STAT:XYZ;OPER", 0, 1);
    ee.push_back(3'h3);
    run("VOLT::CURR;VOLT?;:TRIG", 0, 1);
    xk(5'h0c, 0, 0); xu(1, 0, 0, 0, 0);
    run("VOLT?", 0);
    xk(5'h1f, 0, 0); xk(5'h06, 0, 0); xk(5'h1f, 5'h06, 1); xk(5'h1f, 5'h06, 1);
    xu(0, 0, 0, 0, 0); xu(1, 0, 0, 0, 0); xu(1, 0, 0, 0, 0);
    run("*RST;MEAS:VOLT?;curr?", 0);
    ee.push_back(3'h4);
    run("STAT:QUESTIONABLEX", 0, 1);
    ee.push_back(3'h4);
    run("VOLT 12345678901234567", 0, 1);
    for (int k = 0; k < 25; k++) begin
      int r, v;
      string w, d;
      r = $urandom_range(13);
      v = $urandom_range(999);
      w = mixcase($urandom_range(1) ? roots[r] : short_form(roots[r]));
      d = $sformatf("%0d", v);
      xk(5'(r + 1), 0, 0);
      if (v[0]) begin
        xu(1, 0, 0, 0, 0);
        run({w, "?"}, 1);
      end else begin
        xu(0, 1, 1, 5'(d.len()), d[0]);
        run({w, " ", d}, 1);
      end
    end
    tally_and_finish();
  end
endmodule // test_smp_parser
